// >>> swd_pkg.sv
// Constants and types shared by the system watchdog block
`default_nettype none
package swd_pkg;
    // ********************************
    // I/O port addresses and keys
    // ********************************
    localparam logic [15:0] SWD_INDEX_PORT = 16'h002E;
    localparam logic [15:0] SWD_DATA_PORT  = 16'h002F;
    localparam logic [7:0]  SWD_UNLOCK_KEY = 8'h87;
    localparam logic [7:0]  SWD_LOCK_KEY   = 8'hAA;
    localparam logic [7:0]  SWD_LOCKED_RD  = 8'hFF;
    // ********************************
    // Configuration indexes
    // ********************************
    localparam logic [7:0]  SWD_IDX_LDN      = 8'h07;
    localparam logic [7:0]  SWD_IDX_ENABLE   = 8'h30;
    localparam logic [7:0]  SWD_IDX_ACTIVATE = 8'hF0;
    localparam logic [7:0]  SWD_IDX_UNIT     = 8'hF5;
    localparam logic [7:0]  SWD_IDX_COUNT    = 8'hF6;
    localparam logic [7:0]  SWD_LDN_WATCHDOG = 8'h07;
    // ********************************
    // Field positions and reset values
    // ********************************
    localparam int          SWD_ENABLE_BIT   = 0;
    localparam int          SWD_ACTIVATE_BIT = 7;
    localparam int          SWD_MINUTE_BIT   = 3;
    localparam logic [7:0]  SWD_REG_RESET    = 8'h00;
    // ********************************
    // Timing
    // ********************************
    localparam int          SWD_CLK_HZ         = 125_000_000;
    localparam int          SWD_CLK_PERIOD_NS  = 8;
    localparam int          SWD_TICK_S         = 1;
    localparam int          SWD_CYC_PER_SEC    = SWD_CLK_HZ * SWD_TICK_S;
    localparam int          SWD_SEC_PER_MIN    = 60;
    localparam int          SWD_RST_PULSE_NS   = 1000;
    localparam int          SWD_RST_PULSE_CYC  =
        (SWD_RST_PULSE_NS + SWD_CLK_PERIOD_NS - 1) / SWD_CLK_PERIOD_NS;
    // ********************************
    // Types
    // ********************************
    typedef enum logic [1:0] {
        SWD_CFG_LOCKED = 2'b00,
        SWD_CFG_KEY1   = 2'b01,
        SWD_CFG_OPEN   = 2'b10
    } swd_cfg_t;
endpackage : swd_pkg
`default_nettype wire

// >>> swd_ctl_if.sv
// Control and status link between configuration and countdown logic
`timescale 1ns/100ps
`default_nettype none
interface swd_ctl_if;
    logic       load;
    logic [7:0] load_val;
    logic       run;
    logic       minute;
    logic [7:0] remain;
    logic       expired;
    modport cfg (output load, output load_val, output run, output minute,
                 input remain, input expired);
    modport cnt (input load, input load_val, input run, input minute,
                 output remain, output expired);
endinterface : swd_ctl_if
`default_nettype wire

// >>> swd_countdown.sv
// Time base and down-counter of the system watchdog
`timescale 1ns/100ps
`default_nettype none
module swd_countdown #(
    parameter int unsigned CYC_PER_SEC = swd_pkg::SWD_CYC_PER_SEC
) (
    input  wire logic clk,
    input  wire logic rst_b,
    swd_ctl_if.cnt    ctl
);
    localparam int          PW       = $clog2(CYC_PER_SEC);
    localparam logic [PW-1:0] PS_LAST = PW'(CYC_PER_SEC - 1);
    localparam logic [5:0]  MIN_LAST = 6'(swd_pkg::SWD_SEC_PER_MIN - 1);

    logic [PW-1:0] presc_q;
    logic [5:0]    sec_q;
    logic [7:0]    count_q;
    logic          expired_q;
    logic          sec_tick;
    logic          unit_tick;
    logic          counting;

    assign counting  = ctl.run && (count_q != 8'h00);
    assign sec_tick  = counting && (presc_q == PS_LAST);
    assign unit_tick = ctl.minute ? (sec_tick && sec_q == MIN_LAST) : sec_tick; // RULE7

    // ********************************
    // Time base
    // ********************************
    // Restarted on every reload so the interval is a full unit count
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            presc_q <= '0;
        end else if (ctl.load || !counting || sec_tick) begin
            presc_q <= '0;
        end else begin
            presc_q <= presc_q + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sec_q <= 6'h00;
        end else if (ctl.load || !counting || !ctl.minute) begin
            sec_q <= 6'h00;
        end else if (sec_tick) begin
            sec_q <= (sec_q == MIN_LAST) ? 6'h00 : sec_q + 6'h01; // RULE7
        end
    end

    // ********************************
    // Down-counter
    // ********************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= swd_pkg::SWD_REG_RESET;
        end else if (ctl.load) begin
            count_q <= ctl.load_val; // RULE5
        end else if (unit_tick) begin
            count_q <= count_q - 8'h01; // RULE1
        end
    end

    // Zero never counts, so a loaded zero disables time-out
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            expired_q <= 1'b0;
        end else begin
            expired_q <= !ctl.load && unit_tick && (count_q == 8'h01); // RULE1 RULE8
        end
    end

    assign ctl.remain  = count_q;
    assign ctl.expired = expired_q;

    // ********************************
    // Checks
    // ********************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_load_takes_value: assert property (ctl.load |=> count_q == $past(ctl.load_val)) // RULE5
        else $error("count not taken from loaded value");
    a_second_step: assert property (ctl.run && !ctl.minute && !ctl.load && count_q != 8'h00
        && presc_q == PS_LAST |=> count_q == $past(count_q) - 8'h01) // RULE7
        else $error("second tick did not decrement count");
    a_minute_hold: assert property (ctl.minute && !ctl.load && sec_q != MIN_LAST
        |=> $stable(count_q)) // RULE7
        else $error("count moved before a full minute");
    a_zero_disable: assert property (count_q == 8'h00 && !ctl.load |=> !expired_q) // RULE8
        else $error("time-out raised with zero count");
    a_expire_cause: assert property ($rose(expired_q) |-> count_q == 8'h00
        && $past(count_q) == 8'h01) // RULE1
        else $error("time-out without count reaching zero");
endmodule : swd_countdown
`default_nettype wire

// >>> swd_top.sv
// System watchdog: index/data configuration ports, countdown and reset output
//
// Contract
// (RULE1) Count down from preset value; assert system reset on reaching zero.
// (RULE2) Software loads an initial count and reloads it before expiry.
// (RULE3) Two 87 writes to port 2E open config; index 07 data 07 selects.
// (RULE4) Index 30 enables device, index F0 value 80 activates, before loading.
// (RULE5) Timeout count comes from the byte written at index F6.
// (RULE6) Time base, seconds or minutes, comes from the byte at index F5.
// (RULE7) Unit code 00h ticks each second; 08h ticks each minute.
// (RULE8) Value 00h disables time-out; 01h..FFh expire after that many units.
`timescale 1ns/100ps
`default_nettype none
module swd_top #(
    parameter int unsigned CYC_PER_SEC = swd_pkg::SWD_CYC_PER_SEC
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [15:0] io_addr,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [7:0]  io_wdata,
    output logic      [7:0]  io_rdata,
    output logic             io_rvalid,
    output logic             sys_rst_b
);
    localparam logic [7:0] RST_PULSE = 8'(swd_pkg::SWD_RST_PULSE_CYC);

    swd_pkg::swd_cfg_t cfg_q;
    logic [7:0] index_q;
    logic [7:0] ldn_q;
    logic [7:0] enable_q;
    logic [7:0] activate_q;
    logic [7:0] unit_q;
    logic [7:0] count_val_q;
    logic [7:0] rdata_q;
    logic       rvalid_q;
    logic [7:0] rst_cnt_q;
    logic       sys_rst_b_q;
    logic       load_q;
    logic       idx_wr;
    logic       dat_wr;
    logic       cfg_open;
    logic       wd_sel;
    logic [7:0] reg_rd;

    swd_ctl_if ctl ();

    assign idx_wr   = io_wr && (io_addr == swd_pkg::SWD_INDEX_PORT);
    assign dat_wr   = io_wr && (io_addr == swd_pkg::SWD_DATA_PORT);
    assign cfg_open = (cfg_q == swd_pkg::SWD_CFG_OPEN);
    assign wd_sel   = (ldn_q == swd_pkg::SWD_LDN_WATCHDOG);

    // ********************************
    // Configuration unlock sequence
    // ********************************
    // Any other write between the two keys restarts the sequence
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q <= swd_pkg::SWD_CFG_LOCKED;
        end else begin
            unique case (cfg_q)
                swd_pkg::SWD_CFG_LOCKED: begin
                    if (idx_wr && io_wdata == swd_pkg::SWD_UNLOCK_KEY) begin
                        cfg_q <= swd_pkg::SWD_CFG_KEY1; // RULE3
                    end
                end
                swd_pkg::SWD_CFG_KEY1: begin
                    if (idx_wr && io_wdata == swd_pkg::SWD_UNLOCK_KEY) begin
                        cfg_q <= swd_pkg::SWD_CFG_OPEN; // RULE3
                    end else if (io_wr) begin
                        cfg_q <= swd_pkg::SWD_CFG_LOCKED;
                    end
                end
                swd_pkg::SWD_CFG_OPEN: begin
                    if (idx_wr && io_wdata == swd_pkg::SWD_LOCK_KEY) begin
                        cfg_q <= swd_pkg::SWD_CFG_LOCKED;
                    end
                end
                default: begin
                    cfg_q <= swd_pkg::SWD_CFG_LOCKED;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            index_q <= swd_pkg::SWD_REG_RESET;
        end else if (idx_wr && cfg_open) begin
            index_q <= io_wdata;
        end
    end

    // ********************************
    // Configuration registers
    // ********************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ldn_q <= swd_pkg::SWD_REG_RESET;
        end else if (dat_wr && cfg_open && index_q == swd_pkg::SWD_IDX_LDN) begin
            ldn_q <= io_wdata; // RULE3
        end
    end

    // Device registers answer only while the watchdog device is selected
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            enable_q    <= swd_pkg::SWD_REG_RESET;
            activate_q  <= swd_pkg::SWD_REG_RESET;
            unit_q      <= swd_pkg::SWD_REG_RESET;
            count_val_q <= swd_pkg::SWD_REG_RESET;
        end else if (dat_wr && cfg_open && wd_sel) begin
            unique case (index_q)
                swd_pkg::SWD_IDX_ENABLE:   enable_q    <= io_wdata; // RULE4
                swd_pkg::SWD_IDX_ACTIVATE: activate_q  <= io_wdata; // RULE4
                swd_pkg::SWD_IDX_UNIT:     unit_q      <= io_wdata; // RULE6
                swd_pkg::SWD_IDX_COUNT:    count_val_q <= io_wdata; // RULE5
                default: begin
                end
            endcase
        end
    end

    // Each write of the count reloads the counter
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            load_q <= 1'b0;
        end else begin
            load_q <= dat_wr && cfg_open && wd_sel
                      && index_q == swd_pkg::SWD_IDX_COUNT; // RULE5 RULE2
        end
    end

    assign ctl.load     = load_q;
    assign ctl.load_val = count_val_q;
    assign ctl.run      = enable_q[swd_pkg::SWD_ENABLE_BIT]
                          && activate_q[swd_pkg::SWD_ACTIVATE_BIT]; // RULE4
    assign ctl.minute   = unit_q[swd_pkg::SWD_MINUTE_BIT]; // RULE6 RULE7

    swd_countdown #(
        .CYC_PER_SEC (CYC_PER_SEC)
    ) u_countdown (
        .clk   (clk),
        .rst_b (rst_b),
        .ctl   (ctl.cnt)
    );

    // ********************************
    // Read path
    // ********************************
    // Count reads the live remaining value so software can watch it drain
    always_comb begin
        reg_rd = 8'h00;
        if (index_q == swd_pkg::SWD_IDX_LDN) begin
            reg_rd = ldn_q;
        end else if (wd_sel) begin
            unique case (index_q)
                swd_pkg::SWD_IDX_ENABLE:   reg_rd = enable_q;
                swd_pkg::SWD_IDX_ACTIVATE: reg_rd = activate_q;
                swd_pkg::SWD_IDX_UNIT:     reg_rd = unit_q;
                swd_pkg::SWD_IDX_COUNT:    reg_rd = ctl.remain;
                default:                   reg_rd = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= io_rd;
            if (io_rd) begin
                if (!cfg_open) begin
                    rdata_q <= swd_pkg::SWD_LOCKED_RD;
                end else if (io_addr == swd_pkg::SWD_INDEX_PORT) begin
                    rdata_q <= index_q;
                end else if (io_addr == swd_pkg::SWD_DATA_PORT) begin
                    rdata_q <= reg_rd;
                end else begin
                    rdata_q <= swd_pkg::SWD_LOCKED_RD;
                end
            end
        end
    end

    // ********************************
    // System reset pulse
    // ********************************
    // Fixed width pulse; the system reset is expected to restart this block
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_cnt_q   <= 8'h00;
            sys_rst_b_q <= 1'b1;
        end else begin
            if (ctl.expired) begin
                rst_cnt_q <= RST_PULSE; // RULE1
            end else if (rst_cnt_q != 8'h00) begin
                rst_cnt_q <= rst_cnt_q - 8'h01;
            end
            sys_rst_b_q <= !(ctl.expired || rst_cnt_q > 8'h01); // RULE1
        end
    end

    assign io_rdata  = rdata_q;
    assign io_rvalid = rvalid_q;
    assign sys_rst_b = sys_rst_b_q;

    // ********************************
    // Checks
    // ********************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_key_write;
        idx_wr && io_wdata == swd_pkg::SWD_UNLOCK_KEY;
    endsequence

    a_unlock_two_keys: assert property (cfg_q == swd_pkg::SWD_CFG_LOCKED ##0 s_key_write // RULE3
        ##1 s_key_write |=> cfg_open)
        else $error("two unlock keys did not open configuration");
    a_second_key_opens: assert property (cfg_q == swd_pkg::SWD_CFG_KEY1 ##0 s_key_write // RULE3
        |=> cfg_open)
        else $error("second unlock key did not open configuration");
    a_open_needs_keys: assert property ($rose(cfg_open) |-> $past(idx_wr) // RULE3
        && $past(io_wdata) == swd_pkg::SWD_UNLOCK_KEY)
        else $error("configuration opened without key");
    a_ldn_select: assert property (dat_wr && cfg_open && index_q == swd_pkg::SWD_IDX_LDN
        |=> ldn_q == $past(io_wdata)) // RULE3
        else $error("device select not stored");
    a_run_needs_both: assert property ($rose(ctl.run) |-> $past(dat_wr) && $past(wd_sel)) // RULE4
        else $error("watchdog started without enable and activate");
    a_count_reload: assert property (dat_wr && cfg_open && wd_sel
        && index_q == swd_pkg::SWD_IDX_COUNT |=> load_q ##1 ctl.remain == $past(io_wdata, 2)) // RULE5
        else $error("count write did not reload counter");
    a_unit_select: assert property (dat_wr && cfg_open && wd_sel
        && index_q == swd_pkg::SWD_IDX_UNIT |=> ctl.minute == $past(io_wdata[3])) // RULE6
        else $error("time base not taken from unit byte");
    a_expire_reset: assert property (ctl.expired |=> (!sys_rst_b)[*8]) // RULE1
        else $error("expiry did not hold system reset");
endmodule : swd_top
`default_nettype wire

// >>> swd_top_tb.sv
// Self-checking testbench of the system watchdog block
`timescale 1ns/100ps
`default_nettype none
module swd_top_tb;
    // ********************************
    // Settings and signals
    // ********************************
    localparam int unsigned CPS   = 4;
    localparam int unsigned MIN   = swd_pkg::SWD_SEC_PER_MIN * CPS;
    localparam int          LIMIT = 6000;
    localparam logic [15:0] IDX   = swd_pkg::SWD_INDEX_PORT;
    localparam logic [15:0] DAT   = swd_pkg::SWD_DATA_PORT;
    logic        clk;
    logic        rst_b;
    logic [15:0] io_addr;
    logic        io_wr;
    logic        io_rd;
    logic [7:0]  io_wdata;
    logic [7:0]  io_rdata;
    logic        io_rvalid;
    logic        sys_rst_b;
    int          failures    = 0;
    int          checks_done = 0;
    int          cycles      = 0;

    // Short second so that full-range counts stay cheap to simulate
    swd_top #(.CYC_PER_SEC(CPS)) uut (
        .clk       (clk),
        .rst_b     (rst_b),
        .io_addr   (io_addr),
        .io_wr     (io_wr),
        .io_rd     (io_rd),
        .io_wdata  (io_wdata),
        .io_rdata  (io_rdata),
        .io_rvalid (io_rvalid),
        .sys_rst_b (sys_rst_b)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            stop_test();
        end
    end

    // ********************************
    // Common tasks
    // ********************************
    task automatic stop_test;
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        io_addr  <= a;
        io_wdata <= d;
        io_wr    <= 1'b1;
        @(posedge clk);
        io_wr    <= 1'b0;
    endtask : wr

    // Read data is looked at in its single valid cycle
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        io_addr <= a;
        io_rd   <= 1'b1;
        @(posedge clk);
        io_rd   <= 1'b0;
        #1;
        chk(32'(io_rvalid), 32'h1);
        d = io_rdata;
    endtask : rd

    task automatic cfg(input logic [7:0] idx, input logic [7:0] val);
        wr(IDX, idx);
        wr(DAT, val);
    endtask : cfg

    task automatic expect_cfg(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] d;
        wr(IDX, idx);
        rd(DAT, d);
        chk(32'(d), 32'(exp));
    endtask : expect_cfg

    task automatic quiet(input int n);
        int lows;
        lows = 0;
        repeat (n) begin
            @(posedge clk);
            #1;
            if (sys_rst_b !== 1'b1) begin
                lows++;
            end
        end
        chk(32'(lows), 32'h0);
    endtask : quiet

    // Quiet for n cycles, then a low pulse of the documented width
    task automatic expect_reset(input int n);
        int k;
        quiet(n);
        k = 0;
        while (sys_rst_b !== 1'b0 && k < 12) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk(32'(sys_rst_b), 32'h0);
        k = 0;
        while (sys_rst_b === 1'b0 && k < 200) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk(32'(k), 32'(swd_pkg::SWD_RST_PULSE_CYC));
    endtask : expect_reset

    // ********************************
    // Scenarios
    // ********************************
    task automatic t_locked;
        logic [7:0] d;
        rd(DAT, d);
        chk(32'(d), 32'(swd_pkg::SWD_LOCKED_RD));
        chk(32'(sys_rst_b), 32'h1);
    endtask : t_locked

    task automatic t_unlock;
        wr(IDX, swd_pkg::SWD_UNLOCK_KEY);
        wr(IDX, swd_pkg::SWD_UNLOCK_KEY);
        cfg(swd_pkg::SWD_IDX_ENABLE, 8'h01);
        expect_cfg(swd_pkg::SWD_IDX_ENABLE, 8'h00);
        cfg(swd_pkg::SWD_IDX_LDN, swd_pkg::SWD_LDN_WATCHDOG);
        expect_cfg(swd_pkg::SWD_IDX_LDN, 8'h07);
    endtask : t_unlock

    task automatic t_enable;
        cfg(swd_pkg::SWD_IDX_ENABLE, 8'h01);
        cfg(swd_pkg::SWD_IDX_ACTIVATE, 8'h80);
        expect_cfg(swd_pkg::SWD_IDX_ENABLE, 8'h01);
        expect_cfg(swd_pkg::SWD_IDX_ACTIVATE, 8'h80);
        cfg(swd_pkg::SWD_IDX_UNIT, 8'h00);
        expect_cfg(swd_pkg::SWD_IDX_UNIT, 8'h00);
    endtask : t_enable

    // Ten one-second units; the read takes two cycles of the wait
    task automatic t_seconds;
        logic [7:0] d;
        cfg(swd_pkg::SWD_IDX_COUNT, 8'h0A);
        rd(DAT, d);
        chk(32'(d), 32'h0A);
        expect_reset(10 * CPS - 6);
    endtask : t_seconds

    task automatic t_reload;
        cfg(swd_pkg::SWD_IDX_COUNT, 8'h03);
        repeat (3) begin
            quiet(8);
            wr(DAT, 8'h03);
        end
        quiet(8);
        wr(DAT, 8'h00);
        quiet(300);
    endtask : t_reload

    // Stopped watchdog keeps its count; restarted with zero so nothing fires
    task automatic t_hold;
        cfg(swd_pkg::SWD_IDX_ACTIVATE, 8'h00);
        cfg(swd_pkg::SWD_IDX_COUNT, 8'h02);
        quiet(20);
        expect_cfg(swd_pkg::SWD_IDX_COUNT, 8'h02);
        cfg(swd_pkg::SWD_IDX_COUNT, 8'h00);
        cfg(swd_pkg::SWD_IDX_ACTIVATE, 8'h80);
        wr(IDX, swd_pkg::SWD_IDX_COUNT);
    endtask : t_hold

    task automatic t_max;
        logic [7:0] d;
        wr(DAT, 8'hFF);
        rd(DAT, d);
        chk(32'(d), 32'hFF);
        expect_reset(255 * CPS - 6);
    endtask : t_max

    task automatic t_minute;
        cfg(swd_pkg::SWD_IDX_UNIT, 8'h08);
        cfg(swd_pkg::SWD_IDX_COUNT, 8'h02);
        expect_reset(2 * MIN - 2);
    endtask : t_minute

    // Relocked port refuses writes; unknown ports read back all ones
    task automatic t_relock;
        logic [7:0] d;
        wr(IDX, swd_pkg::SWD_LOCK_KEY);
        rd(DAT, d);
        chk(32'(d), 32'(swd_pkg::SWD_LOCKED_RD));
        wr(IDX, swd_pkg::SWD_IDX_COUNT);
        wr(DAT, 8'h05);
        wr(IDX, swd_pkg::SWD_UNLOCK_KEY);
        wr(IDX, swd_pkg::SWD_UNLOCK_KEY);
        expect_cfg(swd_pkg::SWD_IDX_COUNT, 8'h00);
        rd(16'h0080, d);
        chk(32'(d), 32'(swd_pkg::SWD_LOCKED_RD));
    endtask : t_relock

    // ********************************
    // Main sequence
    // ********************************
    initial begin
        rst_b    = 1'b0;
        io_addr  = 16'h0000;
        io_wr    = 1'b0;
        io_rd    = 1'b0;
        io_wdata = 8'h00;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        t_locked();
        t_unlock();
        t_enable();
        t_seconds();
        t_reload();
        t_hold();
        t_max();
        t_minute();
        t_relock();
        stop_test();
    end
endmodule : swd_top_tb
`default_nettype wire
